// *** rtl/zsc_sram.sv ***
// Pipelined zero-turnaround SRAM with sleep, stall and burst control
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module zsc_sram (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  // SRAM pins
  input  wire logic                           sleep_request,
  input  wire logic                           cycle_hold_n,
  input  wire logic                           select_n,
  input  wire logic                           secondary_select,
  input  wire logic                           tertiary_select_n,
  input  wire logic                           advance_load,
  input  wire logic                           read_write,
  input  wire logic [zsc_pkg::BYTES-1:0]      byte_write_n,
  input  wire logic                           output_enable_n,
  input  wire logic                           burst_order,
  input  wire logic [zsc_pkg::ADDR_W-1:0]     addr,
  input  wire logic [zsc_pkg::DATA_W-1:0]     data_in,
  output logic      [zsc_pkg::DATA_W-1:0]     data_out,
  output logic                                data_oe_n,
  // AXI4-Lite write
  input  wire logic [zsc_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic      [1:0]                     s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  // AXI4-Lite read
  input  wire logic [zsc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic      [31:0]                    s_axi_rdata,
  output logic      [1:0]                     s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready
);
  localparam int AW = zsc_pkg::ADDR_W;
  localparam int DW = zsc_pkg::DATA_W;
  localparam int BW = zsc_pkg::BURST_W;

  logic [zsc_pkg::PIN_W-1:0]  pins_s;
  logic                       sleeping;
  logic                       hold_n_s;
  logic                       sel_n_s;
  logic                       sel2_s;
  logic                       sel3_n_s;
  logic                       adv_s;
  logic                       rw_s;
  logic [zsc_pkg::BYTES-1:0]  bw_n_s;
  logic                       oe_n_s;
  logic                       order_s;
  logic [AW-1:0]              addr_s;
  logic [DW-1:0]              din_s;
  logic                       en;
  logic                       selected;
  logic                       a_valid;
  logic                       a_write;
  logic [AW-1:0]              a_addr;
  logic [zsc_pkg::BYTES-1:0]  a_bw;
  logic [AW-1:0]              a_eff;
  logic                       b_valid;
  logic                       b_write;
  logic [AW-1:0]              b_addr;
  logic [zsc_pkg::BYTES-1:0]  b_bw;
  logic [DW-1:0]              b_data;
  logic                       pend_valid;
  logic [AW-1:0]              pend_addr;
  logic [DW-1:0]              pend_data;
  logic [zsc_pkg::BYTES-1:0]  pend_bw;
  logic                       commit;
  logic [DW-1:0]              fwd_word;
  logic                       out_valid;
  logic                       write_protect;
  logic [31:0]                stall_count;

  // Every pin passes two flops; sleep shares the delay so it lines up
  zsc_sync #(.W(zsc_pkg::PIN_W)) u_sync (
    .clk   (clk),
    .reset (reset),
    .pin   ({sleep_request, cycle_hold_n, select_n, secondary_select,
             tertiary_select_n, advance_load, read_write, byte_write_n,
             output_enable_n, burst_order, addr, data_in}),
    .level (pins_s)
  );

  assign {sleeping, hold_n_s, sel_n_s, sel2_s, sel3_n_s, adv_s, rw_s, bw_n_s,
          oe_n_s, order_s, addr_s, din_s} = pins_s;

  assign en = !sleeping && !hold_n_s;
  assign selected = !sel_n_s && sel2_s && !sel3_n_s;

  zsc_burst_if bif ();

  assign bif.load = en && !adv_s && selected;
  assign bif.advance = en && adv_s && a_valid;
  assign bif.order = order_s;
  assign bif.base = addr_s[BW-1:0];
  assign a_eff = {a_addr[AW-1:BW], bif.addr_low};

  zsc_burst u_burst (
    .clk   (clk),
    .reset (reset),
    .bif   (bif)
  );

  // Address stage; a continuation keeps the loaded cycle type
  always_ff @(posedge clk)
  begin
    if (reset || sleeping)
    begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr  <= '0;
      a_bw    <= '0;
    end
    else if (en && !adv_s)
    begin
      a_valid <= selected;
      a_write <= !rw_s;
      a_addr  <= addr_s;
      a_bw    <= ~bw_n_s;
    end
  end

  // Data stage: write data arrives on the pins here
  always_ff @(posedge clk)
  begin
    if (reset || sleeping)
    begin
      b_valid <= 1'b0;
      b_write <= 1'b0;
      b_addr  <= '0;
      b_bw    <= '0;
      b_data  <= '0;
    end
    else if (en)
    begin
      b_valid <= a_valid;
      b_write <= a_write;
      b_addr  <= a_eff;
      b_bw    <= a_bw;
      b_data  <= din_s;
    end
  end

  // Input data register; the array is written one enabled edge later
  always_ff @(posedge clk)
  begin
    if (reset || sleeping)
      pend_valid <= 1'b0;
    else if (en)
    begin
      pend_valid <= b_valid && b_write;
      if (b_valid && b_write)
      begin
        pend_addr <= b_addr;
        pend_data <= b_data;
        pend_bw   <= b_bw;
      end
    end
  end

  // Write protect drops the write rather than delaying it
  assign commit = en && pend_valid && !write_protect;

  for (genvar g = 0; g < zsc_pkg::BYTES; g++)
  begin : g_lane
    logic [zsc_pkg::BYTE_W-1:0] lane_mem [zsc_pkg::DEPTH];

    always_ff @(posedge clk)
    begin
      if (commit && pend_bw[g])
        lane_mem[pend_addr] <= pend_data[g*zsc_pkg::BYTE_W +: zsc_pkg::BYTE_W];
    end

    assign fwd_word[g*zsc_pkg::BYTE_W +: zsc_pkg::BYTE_W] =
      (pend_valid && pend_bw[g] && !write_protect && pend_addr == b_addr)
        ? pend_data[g*zsc_pkg::BYTE_W +: zsc_pkg::BYTE_W]
        : lane_mem[b_addr];
  end

  // Output register
  always_ff @(posedge clk)
  begin
    if (reset || sleeping)
    begin
      out_valid <= 1'b0;
      data_out  <= '0;
    end
    else if (en)
    begin
      out_valid <= b_valid && !b_write;
      if (b_valid && !b_write)
        data_out <= fwd_word;
    end
  end

  // Output enable only gates read data, so writes never see it
  assign data_oe_n = !(out_valid && !oe_n_s && !sleeping);

  // AXI4-Lite slave: address and data may come in either order
  logic                           aw_hold;
  logic                           w_hold;
  logic [zsc_pkg::AXI_ADDR_W-1:0] aw_addr;
  logic [31:0]                    w_data;
  logic [3:0]                     w_strb;
  logic                           do_write;
  logic [31:0]                    next_rdata;
  logic [1:0]                     next_rresp;

  always_ff @(posedge clk)
  begin
    if (reset)
      stall_count <= '0;
    else if (do_write && aw_addr == zsc_pkg::REG_STALLS)
      stall_count <= (!sleeping && hold_n_s) ? 32'h1 : 32'h0;
    else if (!sleeping && hold_n_s)
      stall_count <= stall_count + 32'h1;
  end

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_strb  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_hold <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_hold <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= zsc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == zsc_pkg::REG_CTRL || aw_addr == zsc_pkg::REG_STALLS)
        s_axi_bresp <= zsc_pkg::RESP_OKAY;
      else if (aw_addr == zsc_pkg::REG_STATUS)
        s_axi_bresp <= zsc_pkg::RESP_OKAY;
      else
        s_axi_bresp <= zsc_pkg::RESP_DECERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      write_protect <= 1'b0;
    else if (do_write && aw_addr == zsc_pkg::REG_CTRL && w_strb[0])
      write_protect <= w_data[zsc_pkg::CTRL_WP_BIT];
  end

  always_comb
  begin
    next_rdata = 32'h0;
    next_rresp = zsc_pkg::RESP_OKAY;
    if (s_axi_araddr == zsc_pkg::REG_CTRL)
      next_rdata[zsc_pkg::CTRL_WP_BIT] = write_protect;
    else if (s_axi_araddr == zsc_pkg::REG_STATUS)
    begin
      next_rdata[zsc_pkg::ST_SLEEP_BIT] = sleeping;
      next_rdata[zsc_pkg::ST_PEND_BIT] = pend_valid;
      next_rdata[zsc_pkg::ST_ORDER_BIT] = order_s;
      next_rdata[zsc_pkg::ST_OUTV_BIT] = out_valid;
    end
    else if (s_axi_araddr == zsc_pkg::REG_STALLS)
      next_rdata = stall_count;
    else
      next_rresp = zsc_pkg::RESP_DECERR;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= zsc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  chk_sleep_hiz: assert property (@(posedge clk) disable iff (reset)
    sleeping |-> data_oe_n ##1 (!out_valid && !a_valid))
    else $error("outputs or pipeline active while asleep");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (reset)
    $rose(sleep_request) |-> ##[1:2] sleeping)
    else $error("sleep not entered within two clocks");
  chk_sleep_exit: assert property (@(posedge clk) disable iff (reset)
    $fell(sleep_request) |-> ##[1:2] !sleeping)
    else $error("sleep not left within two clocks");
  chk_stall_nowrite: assert property (@(posedge clk) disable iff (reset)
    hold_n_s |-> !commit)
    else $error("write committed during a stall");
  chk_stall_hold: assert property (@(posedge clk) disable iff (reset)
    hold_n_s && !sleeping |=> $stable(data_out) && $stable(b_valid) && $stable(b_addr))
    else $error("pipeline moved during a stall");
  chk_wake_clean: assert property (@(posedge clk) disable iff (reset)
    $fell(sleeping) |-> !a_valid && !b_valid && !pend_valid ##1 !b_valid)
    else $error("state left over after sleep");
  chk_read_forward: assert property (@(posedge clk) disable iff (reset)
    en && b_valid && !b_write && pend_valid && !write_protect && pend_bw == 2'h3
      && pend_addr == b_addr |=> data_out == $past(pend_data))
    else $error("read missed data in the input register");
  chk_select_gate: assert property (@(posedge clk) disable iff (reset)
    en && !adv_s && !selected |=> !a_valid)
    else $error("cycle started while deselected");
  chk_oe_read_only: assert property (@(posedge clk) disable iff (reset)
    !data_oe_n |-> out_valid && !oe_n_s)
    else $error("data driven outside a read");

  cov_sleep_cycle: cover property (@(posedge clk) disable iff (reset)
    sleeping ##1 !sleeping);
  cov_forward: cover property (@(posedge clk) disable iff (reset)
    en && b_valid && !b_write && pend_valid && pend_addr == b_addr);
  cov_stall: cover property (@(posedge clk) disable iff (reset)
    b_valid && hold_n_s && !sleeping);
  cov_burst: cover property (@(posedge clk) disable iff (reset) bif.advance [*3]);
endmodule
`default_nettype wire

// *** rtl/zsc_pkg.sv ***
// Shared constants for the synchronous SRAM sleep and cycle control block
package zsc_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 18;
  localparam int BYTES = 2;
  localparam int BYTE_W = 9;
  localparam int BURST_W = 2;
  localparam int PIN_W = 48;
  localparam int DEPTH = 524288;
  localparam logic BURST_LINEAR = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_ENTRY_MAX_CLKS = 2;
  localparam int SLEEP_EXIT_MAX_CLKS = 2;
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_STALLS = 8'h08;
  localparam int CTRL_WP_BIT = 0;
  localparam int ST_SLEEP_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_ORDER_BIT = 2;
  localparam int ST_OUTV_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** rtl/zsc_burst_if.sv ***
// Burst counter hand-off between the pipeline and the counter
`timescale 1ns/1ps
`default_nettype none
interface zsc_burst_if;
  logic                        load;
  logic                        advance;
  logic                        order;
  logic [zsc_pkg::BURST_W-1:0] base;
  logic [zsc_pkg::BURST_W-1:0] addr_low;
  modport pipe (output load, output advance, output order, output base, input addr_low);
  modport counter (input load, input advance, input order, input base, output addr_low);
endinterface
`default_nettype wire

// *** rtl/zsc_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module zsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  logic [W-1:0] meta;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      meta  <= '0;
      level <= '0;
    end
    else
    begin
      meta  <= pin;
      level <= meta;
    end
  end
endmodule
`default_nettype wire

// *** rtl/zsc_burst.sv ***
// Two-bit burst address counter, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
module zsc_burst (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  // Pipeline side
  zsc_burst_if.counter bif
);
  logic [zsc_pkg::BURST_W-1:0] base;
  logic [zsc_pkg::BURST_W-1:0] count;
  logic                        order;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      base  <= '0;
      count <= '0;
      order <= zsc_pkg::BURST_LINEAR;
    end
    else if (bif.load)
    begin
      base  <= bif.base;
      count <= '0;
      order <= bif.order;
    end
    else if (bif.advance)
      count <= count + 2'h1;
  end

  // Interleave flips bits, linear wraps inside the group of four
  assign bif.addr_low = (order == zsc_pkg::BURST_INTERLEAVED) ? (base ^ count)
                                                             : (base + count);

  chk_burst_linear: assert property (@(posedge clk) disable iff (reset)
    bif.advance && !bif.load && order == zsc_pkg::BURST_LINEAR
    |=> bif.addr_low == $past(bif.addr_low) + 2'h1)
    else $error("linear burst did not step by one");
endmodule
`default_nettype wire

// *** verification/zsc_ctl_model.sv ***
// Memory controller model that drives the SRAM pins
`timescale 1ns/1ps
`default_nettype none
module zsc_ctl_model (
  // Clock
  input  wire logic                       clk,
  // SRAM pins
  output logic                            sleep_request,
  output logic                            cycle_hold_n,
  output logic                            select_n,
  output logic                            secondary_select,
  output logic                            tertiary_select_n,
  output logic                            advance_load,
  output logic                            read_write,
  output logic [zsc_pkg::BYTES-1:0]       byte_write_n,
  output logic                            output_enable_n,
  output logic                            burst_order,
  output logic [zsc_pkg::ADDR_W-1:0]      addr,
  output logic [zsc_pkg::DATA_W-1:0]      data_in
);
  initial
  begin
    sleep_request = 1'b0;
    cycle_hold_n = 1'b0;
    output_enable_n = 1'b0;
    burst_order = 1'b0;
    byte_write_n = 2'h3;
    addr = 19'h0;
    data_in = 18'h0;
    select_n = 1'b1;
    secondary_select = 1'b0;
    tertiary_select_n = 1'b1;
    advance_load = 1'b0;
    read_write = 1'b1;
  end

  // Load one cycle; caller must follow with op or idle at return
  task automatic op(input logic rw, input logic [2:0] sel, input logic [18:0] a,
                    input logic [17:0] d, input logic [1:0] be, input int beats);
    {select_n, secondary_select, tertiary_select_n} <= sel;
    advance_load <= 1'b0;
    read_write <= rw;
    addr <= a;
    byte_write_n <= be;
    @(posedge clk);
    data_in <= d;
    // Selects stay valid through continuation cycles
    if (beats > 0)
      advance_load <= 1'b1;
    repeat (beats) @(posedge clk);
  endtask

  // Deselect cycles; released data lines toggle so stale data never looks valid
  task automatic idle(input int n);
    select_n <= 1'b1;
    advance_load <= 1'b0;
    read_write <= 1'b1;
    repeat (n)
    begin
      @(posedge clk);
      data_in <= ~data_in;
    end
  endtask
endmodule
`default_nettype wire

// *** verification/zsc_sram_bench.sv ***
// Self-checking bench for the SRAM sleep and cycle control block
`timescale 1ns/1ps
`default_nettype none
module zsc_sram_bench;
  localparam logic [2:0] SEL = 3'b010;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wire logic sleep_request, cycle_hold_n, select_n, secondary_select, tertiary_select_n;
  wire logic advance_load, read_write, output_enable_n, burst_order, data_oe_n;
  wire logic [1:0] byte_write_n;
  wire logic [zsc_pkg::ADDR_W-1:0] addr;
  wire logic [zsc_pkg::DATA_W-1:0] data_in, data_out;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int miscompares = 0;
  int comparisons = 0;
  logic [17:0] mm [int];

  always #5 clk = ~clk;

  zsc_sram uut (.clk, .reset, .sleep_request, .cycle_hold_n, .select_n, .secondary_select,
    .tertiary_select_n, .advance_load, .read_write, .byte_write_n, .output_enable_n,
    .burst_order, .addr, .data_in, .data_out, .data_oe_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  zsc_ctl_model ctl (.clk, .sleep_request, .cycle_hold_n, .select_n, .secondary_select,
    .tertiary_select_n, .advance_load, .read_write, .byte_write_n, .output_enable_n,
    .burst_order, .addr, .data_in);

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready levels are settled at the falling edge
  task automatic step(inout int n);
    @(negedge clk);
    n++;
    if (n > 100)
    begin
      miscompares++;
      $display("[ERR] %0t bus timeout", $time);
      results();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    logic ap, wp, bp, ra, rw;
    logic [1:0] got;
    int n;
    n = 0;
    ap = 1'b1;
    wp = 1'b1;
    bp = 1'b1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (bp)
    begin
      step(n);
      ra = s_axi_awready;
      rw = s_axi_wready;
      bp = !s_axi_bvalid;
      got = s_axi_bresp;
      @(posedge clk);
      ap = ap && !ra;
      wp = wp && !rw;
      s_axi_awvalid <= ap;
      s_axi_wvalid <= wp;
      s_axi_bready <= bp;
    end
    chk(got, r);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ap, ra, rv;
    logic [31:0] gd;
    logic [1:0] gr;
    int n;
    n = 0;
    ap = 1'b1;
    rv = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv)
    begin
      step(n);
      ra = s_axi_arready;
      rv = s_axi_rvalid;
      gd = s_axi_rdata;
      gr = s_axi_rresp;
      @(posedge clk);
      ap = ap && !ra;
      s_axi_arvalid <= ap;
      s_axi_rready <= !rv;
    end
    chk(gd, d);
    chk(gr, r);
  endtask

  task automatic wr(input logic [18:0] a, input logic [17:0] d, input logic [1:0] be,
                    input logic [2:0] sel, input logic lands);
    ctl.op(1'b0, sel, a, d, be, 0);
    if (lands && !be[0])
      mm[a][8:0] = d[8:0];
    if (lands && !be[1])
      mm[a][17:9] = d[17:9];
  endtask

  // Beat n of a burst shows after the fifth edge past the load, plus n
  task automatic rd(input logic [18:0] a, input int beats, input logic ord);
    logic [18:0] b;
    ctl.burst_order <= ord;
    ctl.op(1'b1, SEL, a, 18'h0, 2'h3, beats);
    ctl.idle(3 - beats);
    for (int n = 0; n <= beats; n++)
    begin
      @(posedge clk);
      #1;
      b = a;
      b[1:0] = ord ? a[1:0] ^ 2'(n) : a[1:0] + 2'(n);
      chk(data_out, mm[b]);
      chk(data_oe_n, 1'b0);
    end
  endtask

  initial
  begin
    s_axi_awaddr <= 8'h0;
    s_axi_araddr <= 8'h0;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'h0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    ctl.idle(4);
    axi_rd(zsc_pkg::REG_CTRL, 32'h0, zsc_pkg::RESP_OKAY);
    axi_rd(zsc_pkg::REG_STATUS, 32'h0, zsc_pkg::RESP_OKAY);
    axi_rd(8'h0c, 32'h0, zsc_pkg::RESP_DECERR);
    axi_wr(8'h10, 32'h1, 4'hf, zsc_pkg::RESP_DECERR);
    for (int i = 0; i < 4; i++)
      wr(19'h40 + 19'(i), 18'h100 + 18'(i), 2'h0, SEL, 1'b1);
    rd(19'h43, 0, 1'b0);
    rd(19'h41, 3, zsc_pkg::BURST_LINEAR);
    rd(19'h41, 3, zsc_pkg::BURST_INTERLEAVED);
    wr(19'h41, 18'h3ffff, 2'h2, SEL, 1'b1);
    rd(19'h41, 0, 1'b0);
    for (int i = 0; i < 3; i++)
      wr(19'h40, 18'h2aaaa, 2'h0, SEL ^ (3'h1 << i), 1'b0);
    rd(19'h40, 0, 1'b0);
    ctl.output_enable_n <= 1'b1;
    wr(19'h44, 18'h15555, 2'h0, SEL, 1'b1);
    ctl.idle(4);
    ctl.output_enable_n <= 1'b0;
    rd(19'h44, 0, 1'b0);
    axi_wr(zsc_pkg::REG_CTRL, 32'h1, 4'he, zsc_pkg::RESP_OKAY);
    axi_rd(zsc_pkg::REG_CTRL, 32'h0, zsc_pkg::RESP_OKAY);
    axi_wr(zsc_pkg::REG_CTRL, 32'h1, 4'h1, zsc_pkg::RESP_OKAY);
    wr(19'h44, 18'h0, 2'h0, SEL, 1'b0);
    ctl.idle(4);
    rd(19'h44, 0, 1'b0);
    axi_wr(zsc_pkg::REG_CTRL, 32'h0, 4'hf, zsc_pkg::RESP_OKAY);
    // Stall lands just after the read data appears
    ctl.op(1'b1, SEL, 19'h43, 18'h0, 2'h3, 0);
    ctl.idle(2);
    ctl.cycle_hold_n <= 1'b1;
    ctl.idle(3);
    wr(19'h42, 18'h0, 2'h0, SEL, 1'b0);
    ctl.idle(4);
    #1;
    chk(data_out, mm[19'h43]);
    chk(data_oe_n, 1'b0);
    ctl.cycle_hold_n <= 1'b0;
    ctl.idle(4);
    rd(19'h42, 0, 1'b0);
    axi_rd(zsc_pkg::REG_STALLS, 32'h8, zsc_pkg::RESP_OKAY);
    // Sleep only once the last read has completed
    ctl.sleep_request <= 1'b1;
    ctl.idle(3);
    #1;
    chk(data_oe_n, 1'b1);
    axi_rd(zsc_pkg::REG_STATUS, 32'h1, zsc_pkg::RESP_OKAY);
    wr(19'h43, 18'h0, 2'h0, SEL, 1'b0);
    ctl.idle(2);
    ctl.sleep_request <= 1'b0;
    ctl.idle(2);
    rd(19'h43, 0, 1'b0);
    axi_rd(zsc_pkg::REG_STATUS, 32'h0, zsc_pkg::RESP_OKAY);
    results();
  end
endmodule
`default_nettype wire
